// File: core/supervisor_cfg.svh
`ifndef SUPERVISOR_CFG_SVH
`define SUPERVISOR_CFG_SVH
// ---------------------------------------------------------------
// timing figures in their own units
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define RESET_STRETCH_MS 200
`define WATCHDOG_TIMEOUT_MS 1600
`define CE_HOLD_US 15
// ---------------------------------------------------------------
// derived cycle counts (125 MHz)
// ---------------------------------------------------------------
`define RESET_STRETCH_CYC ((`RESET_STRETCH_MS * 1000000) / `CLK_PERIOD_NS)
`define WATCHDOG_TIMEOUT_CYC ((`WATCHDOG_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)
`define CE_HOLD_CYC ((`CE_HOLD_US * 1000) / `CLK_PERIOD_NS)
`define RESET_STRETCH_CYC_W 32
`endif

// File: core/supervisor_pkg.sv
package supervisor_pkg;
  // synchronised comparator and pin levels
  typedef struct packed {
    logic main_above_reset;
    logic main_above_backup;
    logic sense_above_fail;
    logic manual_reset_n;
    logic kick_level;
    logic kick_driven;
  } sense_s;
  // gated chip-select phase
  typedef enum logic [1:0] {
    cs_pass,
    cs_hold,
    cs_block
  } cs_state_e;
endpackage

// File: core/supply_supervisor.sv
`timescale 1ns/100ps
`include "supervisor_cfg.svh"
// Contract
// - ram rail comes from main supply when above reset threshold or backup voltage, else from the backup cell.
// - warning output is low when sense is below fail threshold or main is below backup voltage.
// - gated chip-select goes low only when host chip-select is low, and while reset is asserted only within the 15us hold window.
// - a chip-select already low when reset asserts stays low up to 15us or until host raises it, then blocks.
// - on backup cell the gated chip-select is pulled high to the ram rail.
// - a kick input that stays at one level past the watchdog timeout triggers reset.
// - a floating or three-stated kick input disables the watchdog.
// - watchdog timer clears on reset, on three-state kick, and on any kick edge.
// - reset holds while manual reset is low and for 200ms after it rises.
// - reset is held low while main is below threshold or manual reset is low.
// - reset pulses low 200ms once triggered and releases 200ms after the cause ends.
// - the processor must toggle the kick within 1.6s or reset asserts.
// - watchdog timer stays cleared while reset is asserted and counts once it is released.
// - stretch timer clears while main is below threshold and restarts when it returns.
module supply_supervisor
  import supervisor_pkg::*;
#(
  parameter int unsigned STRETCH_CYC = `RESET_STRETCH_CYC,
  parameter int unsigned WATCHDOG_CYC = `WATCHDOG_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // comparator results, asynchronous
  input wire logic main_above_reset,
  input wire logic main_above_backup,
  input wire logic sense_above_fail,
  // processor side pins
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_input,
  input wire logic watchdog_kick_driven,
  input wire logic host_cs_n,
  // outputs
  output logic sys_reset_n,
  output logic power_fail_warn_n,
  output logic rail_from_backup,
  output logic ram_cs_n
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  sense_s raw;
  sense_s sync1, sync2, sync3, stable;
  sense_s next_stable;
  logic host_cs1, host_cs2, host_cs3, host_cs_n_s, next_host_cs_n_s;

  assign raw = '{main_above_reset, main_above_backup, sense_above_fail,
                 manual_reset_n, watchdog_kick_input, watchdog_kick_driven};

  // a change counts once stages two and three agree
  always_comb begin
    next_stable = stable;
    for (int i = 0; i < $bits(sense_s); i++) begin
      if (sync2[i] == sync3[i]) begin
        next_stable[i] = sync3[i];
      end
    end
    next_host_cs_n_s = (host_cs2 == host_cs3) ? host_cs3 : host_cs_n_s;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      stable <= '0;
      host_cs1 <= 1'b1;
      host_cs2 <= 1'b1;
      host_cs3 <= 1'b1;
      host_cs_n_s <= 1'b1;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
      sync3 <= sync2;
      stable <= next_stable;
      host_cs1 <= host_cs_n;
      host_cs2 <= host_cs1;
      host_cs3 <= host_cs2;
      host_cs_n_s <= next_host_cs_n_s;
    end
  end

  // ---------------------------------------------------------------
  // reset generation and watchdog
  // ---------------------------------------------------------------
  logic [31:0] stretch_cnt, next_stretch_cnt;
  logic [31:0] wd_cnt, next_wd_cnt;
  logic kick_prev, next_kick_prev;
  logic next_sys_reset_n;
  logic hold_cause, wd_fire, kick_edge;

  // brownout or manual press keeps reset held with the timer at zero
  assign hold_cause = !stable.main_above_reset || !stable.manual_reset_n;
  assign kick_edge = stable.kick_level != kick_prev;
  assign wd_fire = sys_reset_n && stable.kick_driven && !kick_edge && (wd_cnt >= WATCHDOG_CYC - 1);

  always_comb begin
    next_stretch_cnt = stretch_cnt;
    next_sys_reset_n = sys_reset_n;
    next_wd_cnt = wd_cnt;
    next_kick_prev = stable.kick_level;
    if (hold_cause) begin
      next_sys_reset_n = 1'b0;
      next_stretch_cnt = '0;
    end else if (wd_fire) begin
      next_sys_reset_n = 1'b0;
      next_stretch_cnt = '0;
    end else if (!sys_reset_n) begin
      if (stretch_cnt >= STRETCH_CYC - 1) begin
        next_sys_reset_n = 1'b1;
        next_stretch_cnt = '0;
      end else begin
        next_stretch_cnt = stretch_cnt + 32'h00000001;
      end
    end
    if (!next_sys_reset_n || !sys_reset_n || !stable.kick_driven || kick_edge) begin
      next_wd_cnt = '0;
    end else begin
      next_wd_cnt = wd_cnt + 32'h00000001;
    end
  end

  // reset comes up asserted so the stretch runs after power-on
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stretch_cnt <= '0;
      sys_reset_n <= 1'b0;
      wd_cnt <= '0;
      kick_prev <= 1'b0;
    end else begin
      stretch_cnt <= next_stretch_cnt;
      sys_reset_n <= next_sys_reset_n;
      wd_cnt <= next_wd_cnt;
      kick_prev <= next_kick_prev;
    end
  end

  // ---------------------------------------------------------------
  // supply rail and power-fail warning
  // ---------------------------------------------------------------
  logic next_rail_from_backup, next_warn_n;

  always_comb begin
    next_rail_from_backup = !(stable.main_above_reset || stable.main_above_backup);
    next_warn_n = stable.sense_above_fail && stable.main_above_backup;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rail_from_backup <= 1'b1;
      power_fail_warn_n <= 1'b0;
    end else begin
      rail_from_backup <= next_rail_from_backup;
      power_fail_warn_n <= next_warn_n;
    end
  end

  // ---------------------------------------------------------------
  // chip-select gating
  // ---------------------------------------------------------------
  localparam logic [15:0] CE_HOLD = 16'(`CE_HOLD_CYC);
  cs_state_e cs_state, next_cs_state;
  logic [15:0] cs_cnt, next_cs_cnt;
  logic next_ram_cs_n;

  always_comb begin
    next_cs_state = cs_state;
    next_cs_cnt = cs_cnt;
    next_ram_cs_n = 1'b1;
    case (cs_state)
      cs_pass: begin
        if (!next_sys_reset_n) begin
          next_cs_state = host_cs_n_s ? cs_block : cs_hold;
          next_cs_cnt = '0;
          next_ram_cs_n = host_cs_n_s;
        end else begin
          next_ram_cs_n = host_cs_n_s;
        end
      end
      cs_hold: begin
        if (host_cs_n_s || cs_cnt >= CE_HOLD - 16'h0001) begin
          next_cs_state = cs_block;
        end else begin
          next_cs_cnt = cs_cnt + 16'h0001;
          next_ram_cs_n = 1'b0;
        end
      end
      cs_block: begin
        // stays blocked for the whole stretch, whatever the host does
        if (next_sys_reset_n) begin
          next_cs_state = cs_pass;
          next_ram_cs_n = host_cs_n_s;
        end
      end
      default: begin
        next_cs_state = cs_block;
      end
    endcase
    if (next_rail_from_backup) begin
      next_ram_cs_n = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_state <= cs_block;
      cs_cnt <= '0;
      ram_cs_n <= 1'b1;
    end else begin
      cs_state <= next_cs_state;
      cs_cnt <= next_cs_cnt;
      ram_cs_n <= next_ram_cs_n;
    end
  end

endmodule

// File: test/cpu_model.sv
`timescale 1ns/100ps
module cpu_model (
  // clock and controls
  input wire logic ref_clk,
  input wire logic drive_en,
  input wire logic toggle_en,
  // kick pin
  output logic kick,
  output logic kick_driven
);
  logic [4:0] div = 5'h00;
  initial kick = 1'b0;
  assign kick_driven = drive_en;
  // kick well inside timeout
  // a released line flips every cycle, never a clean held level
  always @(posedge ref_clk) begin
    div <= div + 5'h01;
    if (!drive_en || (toggle_en && div == 5'h1F)) kick <= ~kick;
  end
endmodule

// File: test/supervisor_chk.sv
`timescale 1ns/100ps
module supervisor_chk #(
  parameter int unsigned STRETCH_CYC = 50,
  parameter int unsigned WATCHDOG_CYC = 100
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // comparator and pin inputs
  input wire logic main_above_reset,
  input wire logic main_above_backup,
  input wire logic sense_above_fail,
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_input,
  input wire logic watchdog_kick_driven,
  // outputs
  input wire logic sys_reset_n,
  input wire logic power_fail_warn_n,
  input wire logic rail_from_backup,
  input wire logic ram_cs_n
);
  int unsigned low_cnt;
  int unsigned hold_cnt;
  int unsigned wd_cnt;
  logic kick_q;
  // --------------------------------
  // helper counters
  // --------------------------------
  // counted at the pins, so limits carry the synchroniser slack
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= 0;
      hold_cnt <= 0;
      wd_cnt <= 0;
      kick_q <= 1'b0;
    end else begin
      low_cnt <= sys_reset_n ? 0 : low_cnt + 1;
      hold_cnt <= (!sys_reset_n && !ram_cs_n) ? hold_cnt + 1 : 0;
      wd_cnt <= (!sys_reset_n || !watchdog_kick_driven || kick_q != watchdog_kick_input) ? 0 : wd_cnt + 1;
      kick_q <= watchdog_kick_input;
    end
  end
  // --------------------------------
  // properties
  // --------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  rail_select_a:
    assert property ($stable({main_above_reset, main_above_backup}) [*8] |->
      rail_from_backup == !(main_above_reset | main_above_backup)) else $error("rail select wrong");
  warn_level_a:
    assert property ($stable({sense_above_fail, main_above_backup}) [*8] |->
      power_fail_warn_n == (sense_above_fail & main_above_backup)) else $error("warning level wrong");
  cs_fall_a:
    assert property ($fell(ram_cs_n) |-> sys_reset_n) else $error("select fell in reset");
  cs_hold_a:
    assert property (hold_cnt <= 1880) else $error("select held too long");
  cs_backup_a:
    assert property (rail_from_backup [*3] |-> ram_cs_n) else $error("select low on backup");
  wd_fire_a:
    assert property (wd_cnt <= WATCHDOG_CYC + 10) else $error("watchdog did not fire");
  mr_hold_a:
    assert property (!manual_reset_n [*8] |-> !sys_reset_n) else $error("reset high with manual low");
  brown_hold_a:
    assert property (!main_above_reset [*8] |-> !sys_reset_n) else $error("reset high in brownout");
  stretch_len_a:
    assert property ($rose(sys_reset_n) |-> low_cnt >= STRETCH_CYC) else $error("reset pulse short");
  // main scenarios reached
  cover property ($fell(sys_reset_n) && manual_reset_n && main_above_reset);
  cover property ($rose(ram_cs_n) && !sys_reset_n);
  cover property ($rose(sys_reset_n));
endmodule
bind supply_supervisor supervisor_chk #(.STRETCH_CYC(STRETCH_CYC), .WATCHDOG_CYC(WATCHDOG_CYC)) supervisor_chk_inst (
  .ref_clk, .rst_n, .main_above_reset, .main_above_backup, .sense_above_fail, .manual_reset_n,
  .watchdog_kick_input, .watchdog_kick_driven, .sys_reset_n, .power_fail_warn_n, .rail_from_backup, .ram_cs_n);

// File: test/supply_supervisor_reset_watchdog_tb.sv
`timescale 1ns/100ps
module supply_supervisor_reset_watchdog_tb;
  logic ref_clk = 1'b0, rst_n = 1'b0, mar = 1'b1, mab = 1'b1, saf = 1'b1, manual_reset_n = 1'b1;
  logic host_cs_n = 1'b1, drive_en = 1'b1, toggle_en = 1'b1, kick, kick_drv;
  logic sys_reset_n, power_fail_warn_n, rail_from_backup, ram_cs_n;
  int num_errors = 0, n_tests = 0, cycles = 0;
  supply_supervisor #(.STRETCH_CYC(50), .WATCHDOG_CYC(100)) supply_supervisor_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .main_above_reset(mar), .main_above_backup(mab), .sense_above_fail(saf),
    .manual_reset_n(manual_reset_n), .watchdog_kick_input(kick), .watchdog_kick_driven(kick_drv),
    .host_cs_n(host_cs_n), .sys_reset_n(sys_reset_n), .power_fail_warn_n(power_fail_warn_n),
    .rail_from_backup(rail_from_backup), .ram_cs_n(ram_cs_n));
  cpu_model cpu_model_inst (.ref_clk(ref_clk), .drive_en(drive_en), .toggle_en(toggle_en), .kick(kick),
    .kick_driven(kick_drv));
  always #4 ref_clk = ~ref_clk;
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test;
    end
  end
  task chk(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s exp %b got %b", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task wait_rel(input int lim);
    for (int i = 0; i < lim && sys_reset_n !== 1'b1; i++) cyc(1);
    chk("release", 1'b1, sys_reset_n);
  endtask
  task t_levels;
    logic r, b, s;
    for (int k = 0; k < 8; k++) begin
      {r, b, s} = k[2:0];
      @(posedge ref_clk) {mar, mab, saf} <= {r, b, s};
      cyc(8);
      chk("rail", !(r | b), rail_from_backup);
      chk("warn", s & b, power_fail_warn_n);
      if (!r) chk("brownout", 1'b0, sys_reset_n);
    end
    // release lands about fifty cycles after the supply returns in the k=4 pass
    cyc(10);
    chk("stretch", 1'b0, sys_reset_n);
    wait_rel(40);
  endtask
  task t_manual;
    @(posedge ref_clk) manual_reset_n <= 1'b0;
    cyc(20);
    chk("mr_low", 1'b0, sys_reset_n);
    @(posedge ref_clk) manual_reset_n <= 1'b1;
    cyc(40);
    chk("mr_stretch", 1'b0, sys_reset_n);
    wait_rel(30);
  endtask
  task t_watchdog;
    cyc(300);
    chk("kicked", 1'b1, sys_reset_n);
    @(posedge ref_clk) drive_en <= 1'b0;
    cyc(300);
    chk("floating", 1'b1, sys_reset_n);
    @(posedge ref_clk) {drive_en, toggle_en} <= 2'b10;
    cyc(90);
    chk("wd_clear", 1'b1, sys_reset_n);
    cyc(30);
    chk("wd_fire", 1'b0, sys_reset_n);
    @(posedge ref_clk) toggle_en <= 1'b1;
    wait_rel(80);
  endtask
  task t_cs;
    @(posedge ref_clk) host_cs_n <= 1'b0;
    cyc(8);
    chk("cs_pass", 1'b0, ram_cs_n);
    @(posedge ref_clk) mar <= 1'b0;
    cyc(200);
    chk("cs_hold", 1'b0, ram_cs_n);
    @(posedge ref_clk) host_cs_n <= 1'b1;
    cyc(8);
    chk("cs_end", 1'b1, ram_cs_n);
    @(posedge ref_clk) host_cs_n <= 1'b0;
    cyc(8);
    chk("cs_block", 1'b1, ram_cs_n);
    @(posedge ref_clk) mar <= 1'b1;
    wait_rel(80);
    cyc(8);
    chk("cs_again", 1'b0, ram_cs_n);
    @(posedge ref_clk) mar <= 1'b0;
    cyc(1870);
    chk("cs_window", 1'b0, ram_cs_n);
    cyc(20);
    chk("cs_limit", 1'b1, ram_cs_n);
    @(posedge ref_clk) {mar, host_cs_n} <= 2'b11;
    wait_rel(80);
  endtask
  // host select low when the rail drops to the cell: the pull-up must win over the hold window
  task t_backup;
    @(posedge ref_clk) host_cs_n <= 1'b0;
    cyc(8);
    chk("bk_pass", 1'b0, ram_cs_n);
    @(posedge ref_clk) {mar, mab} <= 2'b00;
    cyc(8);
    chk("bk_rail", 1'b1, rail_from_backup);
    chk("bk_cs", 1'b1, ram_cs_n);
    @(posedge ref_clk) host_cs_n <= 1'b1;
    cyc(8);
    @(posedge ref_clk) {mar, mab} <= 2'b11;
    wait_rel(80);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    cyc(40);
    chk("power_up", 1'b0, sys_reset_n);
    wait_rel(40);
    t_levels;
    t_manual;
    t_watchdog;
    t_cs;
    t_backup;
    end_of_test;
  end
endmodule
